// >>> ccr_pkg.sv
// ccr_pkg: constants and types for the core register set
// assumes: included ahead of every core register set file
package ccr_pkg;

	// ----------------------------------------------------------------
	// flag positions in condition_flags
	// ----------------------------------------------------------------
	localparam int CCR_BIT_CARRY = 0;
	localparam int CCR_BIT_ZERO  = 1;
	localparam int CCR_BIT_NEG   = 2;
	localparam int CCR_BIT_MASK  = 3;
	localparam int CCR_BIT_HALF  = 4;

	// upper three bits and the mask read one after reset; others undefined, held at zero
	localparam logic [7:0] CCR_FLAGS_RESET = 8'he8;

	// ----------------------------------------------------------------
	// stack pointer
	// ----------------------------------------------------------------
	localparam logic [15:0] CCR_SP_RESET   = 16'h017f;
	localparam logic [8:0]  CCR_SP_HIGH    = 9'h002;
	localparam int          CCR_SP_BITS    = 7;
	localparam int          CCR_CALL_BYTES = 2;
	localparam int          CCR_IRQ_BYTES  = 5;

	// ----------------------------------------------------------------
	// operation codes driven by the sequencer
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CCR_OP_NONE,
		CCR_OP_ADD,
		CCR_OP_ADC,
		CCR_OP_LOGIC,
		CCR_OP_SHIFT,
		CCR_OP_SETC,
		CCR_OP_CLRC,
		CCR_OP_SETI,
		CCR_OP_CLRI,
		CCR_OP_WRFLAGS,
		CCR_OP_BTEST
	} ccr_op_type;

	// stack pointer actions
	typedef enum logic [2:0] {
		CCR_SP_HOLD,
		CCR_SP_PUSH,
		CCR_SP_POP,
		CCR_SP_RST,
		CCR_SP_LOAD
	} ccr_spop_type;

endpackage : ccr_pkg

// >>> ccr_stack_ptr.sv
// ccr_stack_ptr: stack pointer with fixed upper bits and wrapping low bits
// assumes: one stack action per cycle from the core sequencer
`timescale 1ns/1ps
module ccr_stack_ptr
	import ccr_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// control
	input  wire ccr_spop_type spOp,
	input  wire logic [7:0]   spLoadData,
	// state
	output logic      [15:0]  stackPointer,
	output logic      [15:0]  popAddr
);

	logic [CCR_SP_BITS-1:0] spLow_ff;
	logic [CCR_SP_BITS-1:0] nxt_spLow;

	// ----------------------------------------------------------------
	// next value
	// ----------------------------------------------------------------
	// seven-bit arithmetic wraps by itself; no overflow flag exists
	always_comb begin
		nxt_spLow = spLow_ff;
		case (spOp)
			CCR_SP_PUSH: nxt_spLow = spLow_ff - 7'h01;
			CCR_SP_POP:  nxt_spLow = spLow_ff + 7'h01;
			CCR_SP_RST:  nxt_spLow = CCR_SP_RESET[CCR_SP_BITS-1:0];
			CCR_SP_LOAD: nxt_spLow = spLoadData[CCR_SP_BITS-1:0];
			default:     nxt_spLow = spLow_ff;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spLow_ff <= CCR_SP_RESET[CCR_SP_BITS-1:0];
		end else begin
			spLow_ff <= nxt_spLow;
		end
	end

	// upper nine bits are constant
	assign stackPointer = {CCR_SP_HIGH, spLow_ff};
	// pop reads the pre-incremented location
	assign popAddr      = {CCR_SP_HIGH, spLow_ff + 7'h01};

endmodule : ccr_stack_ptr

// >>> ccr_flag_calc.sv
// ccr_flag_calc: computes result flags for an alu result
// assumes: operands and carry-in valid in the same cycle as the op code
`timescale 1ns/1ps
module ccr_flag_calc
	import ccr_pkg::*;
(
	// operands
	input  wire logic [7:0] opA,
	input  wire logic [7:0] opB,
	input  wire logic       carryIn,
	input  wire ccr_op_type aluOp,
	input  wire logic [7:0] extResult,
	input  wire logic       extCarry,
	// results
	output logic      [7:0] result,
	output logic            halfCarry,
	output logic            carryOut,
	output logic            negative,
	output logic            zero
);

	logic [4:0] lowSum;
	logic [8:0] fullSum;
	logic       cin;

	always_comb begin
		cin      = (aluOp == CCR_OP_ADC) ? carryIn : 1'b0;
		lowSum   = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
		fullSum  = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
		if (aluOp == CCR_OP_ADD || aluOp == CCR_OP_ADC) begin
			result   = fullSum[7:0];
			carryOut = fullSum[8];
		end else begin
			result   = extResult;
			carryOut = extCarry;
		end
		halfCarry = lowSum[4];
		negative  = result[7];
		zero      = (result == 8'h00);
	end

endmodule : ccr_flag_calc

// >>> ccr_core_regs.sv
// ccr_core_regs: architectural register set of an 8-bit core
// assumes: a core sequencer drives one operation per cycle and
// waits on busy while this block steps context bytes through the stack one byte per cycle
`timescale 1ns/1ps
// What this block does
// - one 8-bit accumulator holding operands and alu results
// - second index register is never stacked on interrupt entry or return
// - 16-bit program counter built from low and high byte registers
// - 8-bit flags register, resets to 111x1xxx
// - half carry set on carry from bit 3 to 4 in add and add-with-carry
// - mask bit 3 set on interrupt entry; blocks all but software break
// - requests arriving while masked are held pending until unmasked
// - interrupt return clears mask; clearing in handler lets pending in
// - negative flag copies result bit 7
// - zero flag set when result is zero, cleared otherwise
// - carry set by arithmetic, set/clear carry, bit test, shift, rotate
// - flags push to and pop from stack; bits individually controllable
// - stack pointer 16 bits, upper nine fixed, seven writable bits
// - reset or reset-stack instruction loads 017f
// - pointer decrements after push, increments before pop
// - pointer wraps at both stack limits without any indication
// - stack pointer low byte loadable and readable
// - interrupt pushes program counter low first; return pops reverse
// - call uses two stack bytes, interrupt uses five
module ccr_core_regs
	import ccr_pkg::*;
#(
	parameter int IRQ_LINES = 4
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// alu operation
	input  wire ccr_op_type           aluOp,
	input  wire logic [7:0]           aluOperand,
	input  wire logic [7:0]           extResult,
	input  wire logic                 extCarry,
	input  wire logic                 accWrite,
	input  wire logic                 xWrite,
	input  wire logic                 yWrite,
	input  wire logic [7:0]           wrData,
	input  wire logic [7:0]           flagsWrData,
	input  wire logic                 bitTestValue,
	// program counter
	input  wire logic                 pcLoad,
	input  wire logic [15:0]          pcLoadValue,
	input  wire logic                 pcInc,
	// stack control
	input  wire logic                 callStart,
	input  wire logic                 returnStart,
	input  wire logic                 irqReturnStart,
	input  wire logic                 pushFlags,
	input  wire logic                 popFlags,
	input  wire ccr_spop_type         spCmd,
	input  wire logic [7:0]           spLoadData,
	input  wire logic [7:0]           memRdData,
	// interrupts
	input  wire logic [IRQ_LINES-1:0] irqReq,
	input  wire logic                 swBreak,
	// register state
	output logic      [7:0]           accumulator,
	output logic      [7:0]           indexX,
	output logic      [7:0]           indexY,
	output logic      [7:0]           program_counter_low_byte,
	output logic      [7:0]           program_counter_high_byte,
	output logic      [7:0]           condition_flags,
	output logic      [15:0]          stack_pointer,
	// stack memory port
	output logic                      memWrite,
	output logic      [15:0]          memAddr,
	output logic      [7:0]           memWrData,
	// interrupt status
	output logic      [IRQ_LINES-1:0] irqPending,
	output logic                      irqTake,
	output logic                      busy
);

	typedef enum {
		SEQ_IDLE,
		SEQ_PUSH,
		SEQ_POP
	} ccr_seq_type;

	typedef enum {
		KIND_CALL,
		KIND_IRQ,
		KIND_RET,
		KIND_RETURN_FROM_INTERRUPT
	} ccr_kind_type;

	// ----------------------------------------------------------------
	// data registers
	// ----------------------------------------------------------------
	logic [7:0]  acc_ff, nxt_acc;
	logic [7:0]  x_ff, nxt_x;
	logic [7:0]  y_ff, nxt_y;
	logic [15:0] pc_ff, nxt_pc;
	logic [7:0]  flags_ff, nxt_flags;

	logic [7:0]  aluResult;
	logic        aluHalf, aluCarry, aluNeg, aluZero;

	ccr_flag_calc u_flag_calc (
		.opA       (acc_ff),
		.opB       (aluOperand),
		.carryIn   (flags_ff[CCR_BIT_CARRY]),
		.aluOp     (aluOp),
		.extResult (extResult),
		.extCarry  (extCarry),
		.result    (aluResult),
		.halfCarry (aluHalf),
		.carryOut  (aluCarry),
		.negative  (aluNeg),
		.zero      (aluZero)
	);

	// ----------------------------------------------------------------
	// stack sequencer state
	// ----------------------------------------------------------------
	ccr_seq_type  seq_ff, nxt_seq;
	ccr_kind_type kind_ff, nxt_kind;
	logic [2:0]   cnt_ff, nxt_cnt;
	logic [IRQ_LINES-1:0] pend_ff, nxt_pend;

	ccr_spop_type spOp;
	logic [15:0]  spValue, popAddr;

	ccr_stack_ptr u_stack_ptr (
		.clk          (clk),
		.rst          (rst),
		.spOp         (spOp),
		.spLoadData   (spLoadData),
		.stackPointer (spValue),
		.popAddr      (popAddr)
	);

	logic masked, takeIrq;
	assign masked  = flags_ff[CCR_BIT_MASK];
	// software break ignores the mask
	assign takeIrq = (seq_ff == SEQ_IDLE) &&
	                 (swBreak || (!masked && (pend_ff != '0)));

	// context byte to write: pcl, pch, x, acc, flags (y never stacked)
	function automatic logic [7:0] push_byte(input logic [2:0] idx);
		case (idx)
			3'd0:    push_byte = pc_ff[7:0];
			3'd1:    push_byte = pc_ff[15:8];
			3'd2:    push_byte = x_ff;
			3'd3:    push_byte = acc_ff;
			3'd4:    push_byte = flags_ff;
			default: push_byte = 8'h00;
		endcase
	endfunction : push_byte

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		nxt_acc   = acc_ff;
		nxt_x     = x_ff;
		nxt_y     = y_ff;
		nxt_pc    = pc_ff;
		nxt_flags = flags_ff;
		nxt_seq   = seq_ff;
		nxt_kind  = kind_ff;
		nxt_cnt   = cnt_ff;
		// masked requests are latched, not dropped
		nxt_pend  = pend_ff | irqReq;
		spOp      = CCR_SP_HOLD;
		memWrite  = 1'b0;
		memAddr   = spValue;
		memWrData = 8'h00;

		case (seq_ff)
			SEQ_IDLE: begin
				if (accWrite)
					nxt_acc = wrData;
				if (xWrite)
					nxt_x = wrData;
				if (yWrite)
					nxt_y = wrData;
				if (pcLoad)
					nxt_pc = pcLoadValue;
				else if (pcInc)
					nxt_pc = pc_ff + 16'h0001;
				case (aluOp)
					CCR_OP_ADD, CCR_OP_ADC: begin
						nxt_acc = aluResult;
						nxt_flags[CCR_BIT_HALF]  = aluHalf;
						nxt_flags[CCR_BIT_CARRY] = aluCarry;
						nxt_flags[CCR_BIT_NEG]   = aluNeg;
						nxt_flags[CCR_BIT_ZERO]  = aluZero;
					end
					CCR_OP_LOGIC: begin
						nxt_acc = aluResult;
						nxt_flags[CCR_BIT_NEG]  = aluNeg;
						nxt_flags[CCR_BIT_ZERO] = aluZero;
					end
					CCR_OP_SHIFT: begin
						nxt_acc = aluResult;
						nxt_flags[CCR_BIT_CARRY] = aluCarry;
						nxt_flags[CCR_BIT_NEG]   = aluNeg;
						nxt_flags[CCR_BIT_ZERO]  = aluZero;
					end
					CCR_OP_BTEST:   nxt_flags[CCR_BIT_CARRY] = bitTestValue;
					CCR_OP_SETC:    nxt_flags[CCR_BIT_CARRY] = 1'b1;
					CCR_OP_CLRC:    nxt_flags[CCR_BIT_CARRY] = 1'b0;
					CCR_OP_SETI:    nxt_flags[CCR_BIT_MASK]  = 1'b1;
					CCR_OP_CLRI:    nxt_flags[CCR_BIT_MASK]  = 1'b0;
					CCR_OP_WRFLAGS: nxt_flags = flagsWrData;
					default:        nxt_flags = flags_ff;
				endcase
				// stack pointer commands and single flag push/pop
				if (pushFlags) begin
					memWrite  = 1'b1;
					memWrData = flags_ff;
					spOp      = CCR_SP_PUSH;
				end else if (popFlags) begin
					memAddr   = popAddr;
					nxt_flags = memRdData;
					spOp      = CCR_SP_POP;
				end else begin
					spOp = spCmd;
				end
				// frame starts: interrupt, then call, interrupt return, return; updates above still apply
				if (takeIrq) begin
					nxt_seq  = SEQ_PUSH;
					nxt_kind = KIND_IRQ;
					nxt_cnt  = 3'd0;
					// a request arriving in the entry cycle stays pending
					if (!swBreak)
						nxt_pend = irqReq;
				end else if (callStart) begin
					nxt_seq  = SEQ_PUSH;
					nxt_kind = KIND_CALL;
					nxt_cnt  = 3'd0;
				end else if (irqReturnStart) begin
					nxt_seq  = SEQ_POP;
					nxt_kind = KIND_RETURN_FROM_INTERRUPT;
					nxt_cnt  = 3'(CCR_IRQ_BYTES - 1);
				end else if (returnStart) begin
					nxt_seq  = SEQ_POP;
					nxt_kind = KIND_RET;
					nxt_cnt  = 3'(CCR_CALL_BYTES - 1);
				end
			end
			SEQ_PUSH: begin
				// write at sp, then decrement
				memWrite  = 1'b1;
				memWrData = push_byte(cnt_ff);
				spOp      = CCR_SP_PUSH;
				nxt_cnt   = cnt_ff + 3'd1;
				if ((kind_ff == KIND_CALL && cnt_ff == 3'(CCR_CALL_BYTES - 1)) ||
				    (kind_ff == KIND_IRQ && cnt_ff == 3'(CCR_IRQ_BYTES - 1))) begin
					nxt_seq = SEQ_IDLE;
					if (kind_ff == KIND_IRQ)
						nxt_flags[CCR_BIT_MASK] = 1'b1;
				end
			end
			SEQ_POP: begin
				// increment, then read: reverse of push order
				memAddr = popAddr;
				spOp    = CCR_SP_POP;
				case (cnt_ff)
					3'd0:    nxt_pc[7:0]  = memRdData;
					3'd1:    nxt_pc[15:8] = memRdData;
					3'd2:    nxt_x        = memRdData;
					3'd3:    nxt_acc      = memRdData;
					3'd4:    nxt_flags    = memRdData;
					default: nxt_pc       = pc_ff;
				endcase
				nxt_cnt = cnt_ff - 3'd1;
				if (cnt_ff == 3'd0) begin
					nxt_seq = SEQ_IDLE;
					if (kind_ff == KIND_RETURN_FROM_INTERRUPT)
						nxt_flags[CCR_BIT_MASK] = 1'b0;
				end
			end
			default: nxt_seq = SEQ_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_ff   <= 8'h00;
			x_ff     <= 8'h00;
			y_ff     <= 8'h00;
			pc_ff    <= 16'h0000;
			flags_ff <= CCR_FLAGS_RESET;
			seq_ff   <= SEQ_IDLE;
			kind_ff  <= KIND_CALL;
			cnt_ff   <= 3'd0;
			pend_ff  <= '0;
		end else begin
			acc_ff   <= nxt_acc;
			x_ff     <= nxt_x;
			y_ff     <= nxt_y;
			pc_ff    <= nxt_pc;
			flags_ff <= nxt_flags;
			seq_ff   <= nxt_seq;
			kind_ff  <= nxt_kind;
			cnt_ff   <= nxt_cnt;
			pend_ff  <= nxt_pend;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign accumulator               = acc_ff;
	assign indexX                    = x_ff;
	assign indexY                    = y_ff;
	assign program_counter_low_byte  = pc_ff[7:0];
	assign program_counter_high_byte = pc_ff[15:8];
	assign condition_flags           = flags_ff;
	assign stack_pointer             = spValue;
	assign irqPending                = pend_ff;
	assign irqTake                   = takeIrq;
	assign busy                      = (seq_ff != SEQ_IDLE);

endmodule : ccr_core_regs

// >>> ccr_core_regs_props.sv
// ccr_core_regs_props: port assertions for the core register set
// assumes: bound into ccr_core_regs, one clock, async high reset
`timescale 1ns/1ps
module ccr_core_regs_props
	import ccr_pkg::*;
#(
	parameter int IRQ_LINES = 4
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// controls
	input wire logic        busy,
	input wire logic        irqTake,
	input wire logic        irqReturnStart,
	input wire logic        callStart,
	input wire logic        swBreak,
	// observed state
	input wire logic        memWrite,
	input wire logic [15:0] memAddr,
	input wire logic [7:0]  memWrData,
	input wire logic [7:0]  indexY,
	input wire logic [7:0]  program_counter_low_byte,
	input wire logic [7:0]  condition_flags,
	input wire logic [15:0] stack_pointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_sp_upper_fixed: assert property (stack_pointer[15:7] == CCR_SP_HIGH)
		else $error("stack pointer upper bits moved");
	// reset itself is the antecedent, so this one stays enabled
	a_reset_values: assert property (disable iff (1'b0) rst |->
		stack_pointer == CCR_SP_RESET && condition_flags == CCR_FLAGS_RESET)
		else $error("reset values wrong");
	a_push_at_free: assert property (memWrite |-> memAddr == stack_pointer)
		else $error("push not at free location");
	a_push_wraps: assert property (memWrite |=>
		stack_pointer[6:0] == $past(stack_pointer[6:0]) - 7'h1)
		else $error("push did not step pointer down");
	a_frame_five: assert property (irqTake |=> memWrite[*5] ##1
		(!busy && condition_flags[CCR_BIT_MASK]))
		else $error("interrupt frame wrong");
	a_irq_low_first: assert property (irqTake |=> memWrData == program_counter_low_byte)
		else $error("first stacked byte not pc low");
	a_mask_blocks: assert property (condition_flags[CCR_BIT_MASK] && !swBreak |-> !irqTake)
		else $error("interrupt taken while masked");
	a_y_unstacked: assert property (busy |=> $stable(indexY))
		else $error("second index changed in frame");
	a_return_from_interrupt_pops: assert property (irqReturnStart && !busy && !irqTake && !callStart |=>
		(memAddr[6:0] == stack_pointer[6:0] + 7'h1)[*5] ##1 !condition_flags[CCR_BIT_MASK])
		else $error("interrupt return wrong");

	c_irq: cover property (irqTake);
	c_return_from_interrupt: cover property (irqReturnStart && !busy);
	c_wrap: cover property (memWrite && stack_pointer == 16'h0100);
endmodule : ccr_core_regs_props

bind ccr_core_regs ccr_core_regs_props #(.IRQ_LINES(IRQ_LINES)) u_props (.*);

// >>> ccr_core_regs_test.sv
// ccr_core_regs_test: self-checking bench for the core register set
// assumes: ccr_pkg and ccr_core_regs compiled first
`timescale 1ns/1ps
module ccr_core_regs_test;
	import ccr_pkg::*;
	logic         clk = 0, rst = 0, extCarry = 0, accWrite = 0, xWrite = 0, yWrite = 0;
	logic         bitTestValue = 0, pcLoad = 0, pcInc = 0, callStart = 0, returnStart = 0;
	logic         irqReturnStart = 0, pushFlags = 0, popFlags = 0, swBreak = 0;
	ccr_op_type   aluOp = CCR_OP_NONE;
	ccr_spop_type spCmd = CCR_SP_HOLD;
	logic [7:0]   aluOperand = '0, extResult = '0, wrData = '0, flagsWrData = '0, spLoadData = '0;
	logic [15:0]  pcLoadValue = '0;
	logic [3:0]   irqReq = '0, irqPending;
	logic [7:0]   accumulator, indexX, indexY, condition_flags, memWrData, memRdData;
	logic [7:0]   program_counter_low_byte, program_counter_high_byte;
	logic [15:0]  stack_pointer, memAddr;
	logic         memWrite, irqTake, busy;
	logic [7:0]   mem [128];
	logic [23:0]  expq [$];
	int           badCount = 0, numChecks = 0;

	ccr_core_regs u_dut (.*);

	always #12.5 clk = ~clk;
	assign memRdData = mem[memAddr[6:0]];

	task automatic wrap_up();
		if (badCount == 0 && numChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(logic [23:0] e, logic [23:0] g);
		numChecks++;
		if (g !== e) begin
			badCount++;
			$display("unexpected t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	task automatic step(int n = 1);
		repeat (n) @(posedge clk);
		#2;
	endtask : step

	// pulses may start a frame; waits for the sequence to finish
	task automatic idle();
		int i;
		step(2);
		for (i = 0; i < 40 && busy !== 1'b0; i++) step();
		if (busy !== 1'b0) begin
			badCount++;
			wrap_up();
		end
	endtask : idle

	task automatic alu(ccr_op_type op, logic [7:0] b);
		aluOp = op;
		aluOperand = b;
		step();
		aluOp = CCR_OP_NONE;
	endtask : alu

	task automatic pulse(ref logic s);
		s = 1;
		step();
		s = 0;
	endtask : pulse

	// ----------------------------------------------------------------
	// stack write monitor and stack memory
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst && memWrite === 1'b1) begin
			mem[memAddr[6:0]] <= memWrData;
			chk(expq.size() ? expq.pop_front() : 24'h0, {memAddr, memWrData});
		end
	end

	initial begin
		#200us;
		badCount++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] a, b;
		logic [8:0] s;
		logic       h, ci;
		foreach (mem[i]) mem[i] = '0;
		// a real rising edge on rst, so the async reset acts before the first clock
		#2;
		rst = 1;
		void'($urandom(64327));
		step(6);
		rst = 0;
		chk(CCR_FLAGS_RESET, condition_flags);
		chk(CCR_SP_RESET, stack_pointer);
		for (int i = 0; i < 10; i++) begin
			a = (i < 3) ? 8'h08 << (i * 2) : 8'($urandom);
			b = (i == 1) ? 8'h80 : (i == 2) ? 8'h01 : (i == 0) ? 8'h08 : 8'($urandom);
			if (i == 2) a = 8'h7f;
			ci = i[0];
			wrData = a;
			pulse(accWrite);
			if (ci) alu(CCR_OP_SETC, '0);
			alu(ci ? CCR_OP_ADC : CCR_OP_ADD, b);
			s = a + b + ci;
			h = ({1'b0, a[3:0]} + b[3:0] + ci) > 5'h0f;
			chk(s[7:0], accumulator);
			chk({h, s[7], s[7:0] == 8'h00, s[8]}, {condition_flags[4], condition_flags[2:0]});
		end
		extResult = 8'h00;
		extCarry = 1;
		alu(CCR_OP_SHIFT, '0);
		chk(3'b011, condition_flags[2:0]);
		extResult = 8'h80;
		alu(CCR_OP_LOGIC, '0);
		chk(2'b10, condition_flags[2:1]);
		alu(CCR_OP_CLRC, '0);
		chk(0, condition_flags[0]);
		bitTestValue = 1;
		alu(CCR_OP_BTEST, '0);
		chk(1, condition_flags[0]);
		// frame context: pc 12c4, x 5a, a a5, y 3c kept off the stack
		pcLoadValue = 16'h12c4;
		pulse(pcLoad);
		wrData = 8'h5a;
		pulse(xWrite);
		wrData = 8'h3c;
		pulse(yWrite);
		wrData = 8'ha5;
		pulse(accWrite);
		flagsWrData = 8'he0;
		alu(CCR_OP_WRFLAGS, '0);
		chk(8'he0, condition_flags);
		repeat (2) expq = {expq, 24'h017fc4, 24'h017e12, 24'h017d5a, 24'h017ca5, 24'h017be0};
		irqReq = 4'h1;
		step();
		irqReq = '0;
		idle();
		chk(16'h017a, stack_pointer);
		chk(8'he8, condition_flags);
		irqReq = 4'h2;
		step();
		irqReq = '0;
		step(3);
		chk(4'h2, irqPending);
		pulse(irqReturnStart);
		idle();
		idle();
		chk(0, expq.size());
		chk(16'h017a, stack_pointer);
		chk({8'h3c, 8'h5a, 8'ha5}, {indexY, indexX, accumulator});
		expq = {expq, 24'h017ac4, 24'h017912};
		pulse(callStart);
		idle();
		chk(16'h0178, stack_pointer);
		pulse(returnStart);
		idle();
		chk(16'h017a, stack_pointer);
		chk(16'h12c4, {program_counter_high_byte, program_counter_low_byte});
		pulse(pcInc);
		chk(16'h12c5, {program_counter_high_byte, program_counter_low_byte});
		spLoadData = 8'h80;
		spCmd = CCR_SP_LOAD;
		step();
		spCmd = CCR_SP_HOLD;
		chk(16'h0100, stack_pointer);
		expq.push_back({16'h0100, condition_flags});
		pulse(pushFlags);
		idle();
		chk(16'h017f, stack_pointer);
		pulse(popFlags);
		idle();
		chk(16'h0100, stack_pointer);
		chk(8'he8, condition_flags);
		// software break is taken although the mask is set; frame wraps at 0100
		expq = {expq, 24'h0100c5, 24'h017f12, 24'h017e5a, 24'h017da5, 24'h017ce8};
		pulse(swBreak);
		idle();
		chk(16'h017b, stack_pointer);
		spCmd = CCR_SP_RST;
		step();
		spCmd = CCR_SP_HOLD;
		chk(CCR_SP_RESET, stack_pointer);
		wrap_up();
	end
endmodule : ccr_core_regs_test
